// ---- pci_system_arbiter.sv ----
// PCI central arbiter: four masters, the expansion bridge and the host.
// Assumes PCI pins arrive asynchronously and are synchronised here;
// host-side inputs come from logic on this clock.
`timescale 1ns/10ps
module pci_system_arbiter
    import arb_pkg::*;
#(
    parameter int TW = arb_pkg::TIMER_W
) (
    // PCI clock, also used by the host side, and reset
    input wire logic clk,
    input wire logic rst_n,
    // Master request/grant pins, active low
    input wire logic [arb_pkg::N_MASTERS-1:0] req_n,
    output logic [arb_pkg::N_MASTERS-1:0] gnt_n,
    // Expansion bridge hold pair, active low
    input wire logic bridge_hold_request_n,
    output logic bridge_hold_ack_n,
    // PCI bus status pins, active low
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic lock_n,
    // Host side, same clock
    input wire logic pci_needs_mem,
    input wire logic host_busy,
    output logic host_grant,
    output logic host_high_prio,
    // Timer presets
    input wire logic [TW-1:0] mtt_preset,
    input wire logic [TW-1:0] mlt_preset,
    // Bus parking drivers
    output logic [31:0] ad_o,
    output logic ad_oe,
    output logic [3:0] cbe_n_o,
    output logic cbe_oe,
    output logic par_o,
    output logic par_oe
);
    import arb_pkg::*;

    // Pin synchronisers: first stage feeds second only
    // Bits: 3..0 requests, 4 bridge, 5 frame, 6 irdy, 7 lock
    logic [7:0] pin_s1_r, pin_s2_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 8'hff;
            pin_s2_r <= 8'hff;
        end else begin
            pin_s1_r <= {lock_n, irdy_n, frame_n, bridge_hold_request_n, req_n};
            pin_s2_r <= pin_s1_r;
        end
    end

    logic [N_AGENTS-1:0] req;
    logic frame_act, bus_idle, locked;
    assign req = ~pin_s2_r[4:0];
    assign frame_act = ~pin_s2_r[5];
    assign bus_idle = pin_s2_r[5] & pin_s2_r[6];
    assign locked = ~pin_s2_r[7];

    // Timers
    logic mtt_load, mlt_load, wait_load;
    logic mtt_run, mlt_run;
    logic [WAIT_W-1:0] wait_cnt;

    down_timer #(.W(TW)) u_mtt (
        .clk(clk),
        .rst_n(rst_n),
        .load(mtt_load),
        .preset(mtt_preset),
        .count_r(),
        .running(mtt_run)
    );

    down_timer #(.W(TW)) u_mlt (
        .clk(clk),
        .rst_n(rst_n),
        .load(mlt_load),
        .preset(mlt_preset),
        .count_r(),
        .running(mlt_run)
    );

    down_timer #(.W(WAIT_W)) u_gnt_wait (
        .clk(clk),
        .rst_n(rst_n),
        .load(wait_load),
        .preset(GNT_WAIT_LOAD),
        .count_r(wait_cnt),
        .running()
    );

    // Arbitration state
    arb_state_e state_r, state_nxt;
    logic [2:0] top_r, top_nxt;
    logic [2:0] last_r, last_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic cpu_hi_r, cpu_hi_nxt;
    logic [N_MASTERS-1:0] gnt_n_r, gnt_n_nxt;
    logic ack_n_r, ack_n_nxt;
    logic host_r, host_nxt;
    logic park_r, park_nxt;

    // Ring search from the top pointer
    logic [N_AGENTS-1:0] masked;
    logic found;
    logic [2:0] winner;
    logic [2:0] idx;
    always_comb begin
        masked = req;
        // Bridge at the bottom yields to pending masters
        if (top_r == FIRST_IDX && req[N_MASTERS-1:0] != '0) begin
            masked[BRIDGE_IDX] = 1'b0;
        end
        found = 1'b0;
        winner = top_r;
        idx = top_r;
        for (int i = 0; i < N_AGENTS; i++) begin
            if (!found && masked[idx]) begin
                found = 1'b1;
                winner = idx;
            end
            idx = (idx == BRIDGE_IDX) ? FIRST_IDX : idx + 3'h1;
        end
        // Recently granted agent promoted while the window is open
        if (mtt_run && masked[last_r]) begin
            found = 1'b1;
            winner = last_r;
        end
    end

    logic cpu_high;
    assign cpu_high = (cnt_r == PCI_GRANTS_FOR_CPU);

    // Next-state and grant decisions
    always_comb begin
        state_nxt = state_r;
        top_nxt = top_r;
        last_nxt = last_r;
        cnt_nxt = cnt_r;
        cpu_hi_nxt = cpu_hi_r;
        gnt_n_nxt = gnt_n_r;
        ack_n_nxt = ack_n_r;
        host_nxt = host_r;
        mtt_load = 1'b0;
        mlt_load = 1'b0;
        wait_load = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (bus_idle && cpu_high) begin
                    host_nxt = 1'b1;
                    cpu_hi_nxt = 1'b1;
                    mlt_load = 1'b1;
                    cnt_nxt = CNT_RESET;
                    state_nxt = ST_CPU_GNT;
                end else if (bus_idle && found) begin
                    // One grant only, chosen from the ring
                    gnt_n_nxt = '1;
                    if (winner == BRIDGE_IDX) begin
                        ack_n_nxt = 1'b0;
                    end else begin
                        gnt_n_nxt[winner[1:0]] = 1'b0;
                    end
                    // Collapse grants inside the window into one
                    if (winner != last_r && !mtt_run && cnt_r != PCI_GRANTS_FOR_CPU) begin
                        cnt_nxt = cnt_r + 2'h1;
                    end
                    last_nxt = winner;
                    top_nxt = (winner == BRIDGE_IDX) ? FIRST_IDX : winner + 3'h1;
                    mtt_load = 1'b1;
                    wait_load = 1'b1;
                    state_nxt = ST_PCI_GNT;
                end else if (bus_idle && !pci_needs_mem && !locked) begin
                    host_nxt = 1'b1;
                    cpu_hi_nxt = 1'b0;
                    cnt_nxt = CNT_RESET;
                    state_nxt = ST_CPU_GNT;
                end
            end
            ST_PCI_GNT: begin
                // Release on frame, or when the wait runs out
                if (frame_act) begin
                    gnt_n_nxt = '1;
                    ack_n_nxt = 1'b1;
                    state_nxt = ST_PCI_BUSY;
                end else if (wait_cnt == GNT_WAIT_LAST) begin
                    gnt_n_nxt = '1;
                    ack_n_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_PCI_BUSY: begin
                if (bus_idle) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_CPU_GNT: begin
                // High priority host is held until the latency timer ends
                if (!host_busy && req != '0 && !(cpu_hi_r && mlt_run)) begin
                    host_nxt = 1'b0;
                    cpu_hi_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                gnt_n_nxt = '1;
                ack_n_nxt = 1'b1;
                host_nxt = 1'b0;
            end
        endcase
        // Park when nobody owns the bus and it is idle
        park_nxt = bus_idle && gnt_n_nxt == '1 && ack_n_nxt && !host_nxt;
    end

    // State registers, cleared without a clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            top_r <= TOP_RESET;
            last_r <= TOP_RESET;
            cnt_r <= CNT_RESET;
            cpu_hi_r <= 1'b0;
            gnt_n_r <= '1;
            ack_n_r <= 1'b1;
            host_r <= 1'b0;
            park_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            top_r <= top_nxt;
            last_r <= last_nxt;
            cnt_r <= cnt_nxt;
            cpu_hi_r <= cpu_hi_nxt;
            gnt_n_r <= gnt_n_nxt;
            ack_n_r <= ack_n_nxt;
            host_r <= host_nxt;
            park_r <= park_nxt;
        end
    end

    // Outputs straight from flip-flops; parked values are constant zero
    assign gnt_n = gnt_n_r;
    assign bridge_hold_ack_n = ack_n_r;
    assign host_grant = host_r;
    assign host_high_prio = cpu_hi_r;
    assign ad_o = AD_PARK;
    assign cbe_n_o = CBE_PARK;
    assign par_o = PAR_PARK;
    assign ad_oe = park_r;
    assign cbe_oe = park_r;
    assign par_oe = park_r;
endmodule

// ---- arb_pkg.sv ----
// Shared constants for the PCI system arbiter.
// Assumes one PCI clock domain; all counts are in PCI clocks.
package arb_pkg;
    // Clock period of the PCI clock in ns
    localparam int CLK_PERIOD_NS = 100;
    // Agent ring: four general masters, then the expansion bridge
    localparam int N_AGENTS = 5;
    localparam int N_MASTERS = 4;
    localparam logic [2:0] BRIDGE_IDX = 3'h4;
    localparam logic [2:0] FIRST_IDX = 3'h0;
    // Grant must see a frame within this many PCI clocks
    localparam int GNT_TIMEOUT_CLKS = 16;
    localparam int WAIT_W = 5;
    localparam logic [WAIT_W-1:0] GNT_WAIT_LOAD = WAIT_W'(GNT_TIMEOUT_CLKS);
    localparam logic [WAIT_W-1:0] GNT_WAIT_LAST = 5'h01;
    // Consecutive PCI grants before the host turns high priority
    localparam logic [1:0] PCI_GRANTS_FOR_CPU = 2'h3;
    // Width of the two programmable timers
    localparam int TIMER_W = 8;
    // Reset and parking values
    localparam logic [2:0] TOP_RESET = 3'h0;
    localparam logic [1:0] CNT_RESET = 2'h0;
    localparam logic [31:0] AD_PARK = 32'h0000_0000;
    localparam logic [3:0] CBE_PARK = 4'h0;
    localparam logic PAR_PARK = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PCI_GNT,
        ST_PCI_BUSY,
        ST_CPU_GNT
    } arb_state_e;
endpackage

// ---- down_timer.sv ----
// Loadable down counter that stops at zero.
// Assumes load comes from logic on the same clock.
`timescale 1ns/10ps
module down_timer #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic load,
    input wire logic [W-1:0] preset,
    // State
    output logic [W-1:0] count_r,
    output logic running
);
    logic [W-1:0] count_nxt;

    // Load wins, otherwise count down to zero
    always_comb begin
        count_nxt = count_r;
        if (load) begin
            count_nxt = preset;
        end else if (count_r != '0) begin
            count_nxt = count_r - W'(1);
        end
    end

    // Register with asynchronous clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign running = (count_r != '0);
endmodule

// ---- arb_props.sv ----
// Assertions on the PCI arbiter pins.
// Assumes it is bound to every arbiter instance and sees its ports only.
`timescale 1ns/10ps
module arb_props
    import arb_pkg::*;
#(
    parameter int TW = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Masters, bridge and frame
    input wire logic [N_MASTERS-1:0] req_n,
    input wire logic [N_MASTERS-1:0] gnt_n,
    input wire logic bridge_hold_request_n,
    input wire logic bridge_hold_ack_n,
    input wire logic frame_n,
    // Host side
    input wire logic host_busy,
    input wire logic host_grant,
    input wire logic host_high_prio,
    input wire logic [TW-1:0] mlt_preset,
    // Parking
    input wire logic [31:0] ad_o,
    input wire logic ad_oe
);
    logic [TW:0] hp_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Cycles the host has held a high priority grant
    always_ff @(posedge clk) begin
        hp_cnt <= (host_grant && host_high_prio && rst_n) ? hp_cnt + 1'b1 : '0;
    end
    a_single_owner: assert property (
        $onehot0({~gnt_n, ~bridge_hold_ack_n, host_grant})) else $error("two owners");
    a_park_zeros: assert property (ad_o == 32'h0) else $error("park not zero");
    a_park_off: assert property (
        !(&gnt_n && bridge_hold_ack_n) |-> !ad_oe) else $error("parking while granted");
    a_master_asked: assert property (
        (~gnt_n & $past(gnt_n) & $past(req_n, 2)) == 4'h0) else $error("unasked grant");
    a_bridge_asked: assert property (
        $fell(bridge_hold_ack_n) |-> !$past(bridge_hold_request_n, 2)) else $error("unasked ack");
    a_grant_bound: assert property (
        $fell(gnt_n[1]) |-> ##[1:16] gnt_n[1]) else $error("grant overstays");
    a_frame_drop: assert property (
        $fell(frame_n) && !gnt_n[0] |-> ##[1:4] gnt_n[0]) else $error("grant kept after frame");
    a_host_yields: assert property (
        $fell(host_grant) |-> !$past(host_busy)) else $error("host dropped while busy");
    a_mlt_served: assert property (
        $fell(host_grant) && $past(host_high_prio) |-> hp_cnt >= mlt_preset)
        else $error("host service cut short");
    a_prio_owned: assert property (host_high_prio |-> host_grant) else $error("prio alone");
    c_master: cover property ($fell(gnt_n[0]));
    c_bridge: cover property ($fell(bridge_hold_ack_n));
    c_high: cover property ($rose(host_high_prio));
endmodule

bind pci_system_arbiter arb_props #(.TW(TW)) u_props (.*);

// ---- pci_agents_model.sv ----
// Four PCI masters and the expansion bridge, one short cycle per grant.
// Assumes the bench raises go bits for one clock to queue requests.
`timescale 1ns/10ps
module pci_agents_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Scenario control
    input wire logic [4:0] go,
    input wire logic quiet,
    // Grants from the arbiter
    input wire logic [3:0] gnt_n,
    input wire logic bridge_hold_ack_n,
    // Requests and bus status, active low
    output logic [3:0] req_n,
    output logic bridge_hold_request_n,
    output logic frame_n = 1'b1,
    output logic irdy_n = 1'b1
);
    logic [4:0] pend = 5'h00;
    logic [1:0] run = 2'h0;
    logic start;
    wire [4:0] won = {~bridge_hold_ack_n, ~gnt_n} & pend;
    // Pending agents hold their request low until served
    assign req_n = ~pend[3:0];
    assign bridge_hold_request_n = ~pend[4];
    assign start = |won && !quiet && run == 2'h0 && frame_n;
    // Frame for one clock, irdy for three; quiet agents give up unused
    always @(posedge clk) begin
        if (!rst_n) begin
            pend <= 5'h00;
            run <= 2'h0;
            frame_n <= 1'b1;
            irdy_n <= 1'b1;
        end else begin
            pend <= (pend & ~((quiet || start) ? won : 5'h00)) | go;
            run <= start ? 2'h2 : (run != 2'h0 ? run - 2'h1 : 2'h0);
            frame_n <= !start;
            irdy_n <= !(start || run != 2'h0);
        end
    end
endmodule

// ---- pci_system_arbiter_test.sv ----
// Self-checking bench for the PCI arbiter with the agents model.
// Assumes a 100 ns clock and no other clock.
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("Error %0t: got %0h want %0h", $time, a, e); end end
module pci_system_arbiter_test;
    import arb_pkg::*;
    logic clk = 0, rst_n = 0, lock_n = 1, pci_needs_mem = 0, host_busy = 0, quiet = 0;
    logic [7:0] mtt_preset = 8'h01, mlt_preset = 8'h05;
    logic [4:0] go = 5'h00;
    logic [3:0] req_n, gnt_n, cbe_n_o;
    logic [31:0] ad_o;
    logic frame_n, irdy_n, bridge_hold_request_n, bridge_hold_ack_n, host_grant;
    logic host_high_prio, ad_oe, cbe_oe, par_oe, par_o, saw_hp = 0;
    int n_errors = 0, total_checks = 0;
    wire [4:0] gv = {~bridge_hold_ack_n, ~gnt_n};
    pci_system_arbiter dut (.*);
    pci_agents_model peers (.*);
    // Clock and a watchdog against hangs
    initial forever #50 clk = ~clk;
    initial begin
        #1000000;
        n_errors++;
        end_of_test;
    end
    // Remember any high priority host turn
    always @(posedge clk) if (host_high_prio === 1'b1) saw_hp <= 1'b1;
    task tick; @(posedge clk); #1; endtask
    task end_of_test;
        if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task send(input logic [4:0] m); go = m; tick; go = 5'h00; endtask
    // Wait for the next agent grant, check it, wait for its release
    task automatic next_gnt(input logic [4:0] e);
        int k = 0;
        while (gv === 5'h00 && k < 300) begin tick; k++; end
        `CHK(gv, e)
        while (gv !== 5'h00 && k < 600) begin tick; k++; end
    endtask
    task t_reset;
        `CHK({gnt_n, bridge_hold_ack_n, host_grant, host_high_prio}, 7'h7c)
        `CHK({ad_oe, cbe_oe, par_oe, ad_o, cbe_n_o, par_o}, {3'h7, 37'h0})
    endtask
    task t_lock;
        // Keep the host off until the lock pin has crossed the synchroniser
        pci_needs_mem = 1;
        lock_n = 0;
        repeat (3) tick;
        pci_needs_mem = 0;
        repeat (20) tick;
        `CHK(host_grant, 1'b0)
        lock_n = 1;
        repeat (6) tick;
        `CHK({host_grant, host_high_prio}, 2'b10)
    endtask
    task t_ring;
        host_busy = 1;
        send(5'h1f);
        repeat (10) tick;
        `CHK(host_grant, 1'b1)
        host_busy = 0;
        next_gnt(5'h01);
        next_gnt(5'h02);
        next_gnt(5'h04);
        next_gnt(5'h08);
        next_gnt(5'h10);
        send(5'h18);
        next_gnt(5'h08);
        next_gnt(5'h10);
        `CHK(saw_hp, 1'b1)
    endtask
    task t_mtt;
        mtt_preset = 8'h40;
        pci_needs_mem = 1;
        send(5'h04);
        next_gnt(5'h04);
        send(5'h0c);
        next_gnt(5'h04);
        next_gnt(5'h08);
    endtask
    task automatic t_timeout;
        int n = 0;
        quiet = 1;
        send(5'h02);
        while (gv !== 5'h02 && n < 100) begin tick; n++; end
        n = 0;
        while (gnt_n[1] === 1'b0 && n < 40) begin
            `CHK(ad_oe, 1'b0)
            n++;
            tick;
        end
        `CHK(n, 16)
        `CHK({ad_oe, cbe_oe, par_oe}, 3'h7)
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        #1;
        t_reset;
        rst_n = 1;
        t_lock;
        t_ring;
        t_mtt;
        t_timeout;
        end_of_test;
    end
endmodule
